// *** spss_pkg.sv ***
// Constants and types shared by the spectral power state sequencer
`default_nettype none
package spss_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_PS = 20000;
    localparam int INIT_TIME_NS = 200000;
    localparam int INIT_CYCLES = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BASE_TICK_PS = 2780000;
    localparam int TICK_CYCLES = BASE_TICK_PS / CLK_PERIOD_PS;
    localparam int WAIT_TICKS = 1000;
    // Widths and counts
    localparam int DATA_W = 16;
    localparam int NUM_CONV = 6;
    localparam int NUM_PASS = 2;
    localparam int NUM_RES = NUM_CONV * NUM_PASS;
    localparam int STEP_SIZE_W = 16;
    localparam int STEP_COUNT_W = 8;
    localparam int GAIN_W = 4;
    // Reset values
    localparam logic NACK_RST = 1'h1;
    localparam logic GPIO_OEN_RST = 1'h0;
    // Power and measurement states
    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_SLEEP = 3'b001,
        ST_IDLE = 3'b010,
        ST_MEASURE = 3'b011,
        ST_WAIT = 3'b100
    } spss_state_t;
endpackage
`default_nettype wire

// *** spss_conv_if.sv ***
// Link between the sequencer and the converter bank
`timescale 1ns/1ps
`default_nettype none
interface spss_conv_if;
    logic tick;
    logic start;
    logic abort;
    logic [spss_pkg::GAIN_W-1:0] gain;
    logic [spss_pkg::STEP_COUNT_W-1:0] stepCount;
    logic [spss_pkg::STEP_SIZE_W-1:0] stepSize;
    logic busy;
    logic done;
    logic [spss_pkg::NUM_CONV-1:0][spss_pkg::DATA_W-1:0] result;
    modport ctrl (output tick, start, abort, gain, stepCount, stepSize,
        input busy, done, result);
    modport conv (input tick, start, abort, gain, stepCount, stepSize,
        output busy, done, result);
endinterface
`default_nettype wire

// *** spss_converter.sv ***
// Six-channel integrating converter bank with step timer
`timescale 1ns/1ps
`default_nettype none
module spss_converter (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Photodiode charge pulses, one per converter
    input wire logic [spss_pkg::NUM_CONV-1:0] photoPulse,
    // Sequencer side
    spss_conv_if.conv cif
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [spss_pkg::STEP_SIZE_W-1:0] stepCnt;
        logic [spss_pkg::STEP_COUNT_W-1:0] cnt;
        logic [spss_pkg::NUM_CONV-1:0][spss_pkg::DATA_W-1:0] acc;
    } spss_conv_st_t;
    spss_conv_st_t r_reg, r_next;
    logic [spss_pkg::NUM_CONV-1:0][spss_pkg::DATA_W-1:0] satSum;
    logic [spss_pkg::DATA_W-1:0] gainIncr;

    ////////////////////////////////////////////////////////////////////////
    // Gain sets the weight of each charge pulse
    assign gainIncr = spss_pkg::DATA_W'(1) << cif.gain;

    // Saturating accumulators, one per converter
    genvar g;
    generate
        for (g = 0; g < spss_pkg::NUM_CONV; g++) begin : gen_acc
            logic [spss_pkg::DATA_W:0] sum;
            assign sum = {1'b0, r_reg.acc[g]} + (photoPulse[g] ? {1'b0, gainIncr} : '0);
            assign satSum[g] = sum[spss_pkg::DATA_W] ? '1 : sum[spss_pkg::DATA_W-1:0];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Integration timer: step size plus one ticks per step, step count plus one steps
    always_comb begin
        r_next = r_reg;
        r_next.done = 1'b0;
        if (cif.abort) begin
            r_next.busy = 1'b0;
        end else if (cif.start) begin
            r_next.busy = 1'b1;
            r_next.stepCnt = '0;
            r_next.cnt = '0;
            r_next.acc = '0;
        end else if (r_reg.busy) begin
            r_next.acc = satSum;
            if (cif.tick) begin
                if (r_reg.stepCnt == cif.stepSize) begin
                    r_next.stepCnt = '0;
                    if (r_reg.cnt == cif.stepCount) begin
                        r_next.busy = 1'b0;
                        r_next.done = 1'b1;
                    end else begin
                        r_next.cnt = r_reg.cnt + 1'b1;
                    end
                end else begin
                    r_next.stepCnt = r_reg.stepCnt + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign cif.busy = r_reg.busy;
    assign cif.done = r_reg.done;
    assign cif.result = r_reg.acc;

    ////////////////////////////////////////////////////////////////////////
    // Helper: ticks seen during one integration
    logic [23:0] tickSeen;
    always_ff @(posedge sys_clk) begin
        if (sys_rst || cif.start) begin
            tickSeen <= '0;
        end else if (r_reg.busy && cif.tick) begin
            tickSeen <= tickSeen + 24'h1;
        end
    end

    property p_integLen;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(r_reg.done) |-> tickSeen == 24'((cif.stepCount + 24'h1) * (cif.stepSize + 24'h1));
    endproperty
    a_integLen: assert property (p_integLen) else $error("integration length wrong");

    property p_accMono;
        @(posedge sys_clk) disable iff (sys_rst)
        (r_reg.busy && !cif.start && !cif.abort) |=> r_reg.acc[0] >= $past(r_reg.acc[0]);
    endproperty
    a_accMono: assert property (p_accMono) else $error("accumulator went down");
endmodule // spss_converter
`default_nettype wire

// *** spss_sequencer.sv ***
// Power and measurement state sequencer, top level
`timescale 1ns/1ps
`default_nettype none
module spss_sequencer #(
    parameter int unsigned INIT_CYCLES = spss_pkg::INIT_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Control bits
    input wire logic powerOnBit,
    input wire logic measureEnableBit,
    input wire logic waitEnableBit,
    input wire logic sleepAfterIrqBit,
    input wire logic irqSleepClear,
    input wire logic irqClear,
    input wire logic gpioSyncEnable,
    input wire logic ledSyncEnable,
    input wire logic ledEnable,
    // Timing and gain settings
    input wire logic [7:0] integStepCount,
    input wire logic [15:0] integStepSize,
    input wire logic [7:0] waitTime,
    input wire logic [3:0] analogGainSetting,
    // Threshold settings
    input wire logic [15:0] thresholdLow,
    input wire logic [15:0] thresholdHigh,
    input wire logic [2:0] thresholdChannel,
    // Serial bus activity
    input wire logic i2cActive,
    // Photodiode charge pulses
    input wire logic [5:0] photoPulse,
    // Result read port
    input wire logic [3:0] resultAddr,
    output logic [15:0] resultData,
    // Status
    output logic [2:0] powerState,
    output logic oscEnable,
    output logic measureCircuitOn,
    output logic i2cNack,
    output logic i2cWake,
    output logic irqSleepFlag,
    output logic dataValid,
    // Pins
    output logic intOut,
    output logic intOeN,
    input wire logic gpioIn,
    output logic gpioOut,
    output logic gpioOeN,
    output logic ledDriverPin
);
    typedef struct packed {
        spss_pkg::spss_state_t st;
        logic [13:0] initCnt;
        logic [7:0] tickCnt;
        logic tick;
        logic [9:0] waitCnt;
        logic [7:0] waitSteps;
        logic pass;
        logic start;
        logic abort;
        logic irqPend;
        logic irqSleep;
        logic nack;
        logic wake;
        logic osc;
        logic meas;
        logic gpioOeN;
        logic gpioOut;
        logic led;
        logic valid;
        logic [spss_pkg::NUM_RES-1:0][spss_pkg::DATA_W-1:0] mem;
        logic [15:0] readData;
    } spss_seq_st_t;
    spss_seq_st_t r_reg, r_next;
    spss_conv_if cif ();
    logic measureRun;
    logic irqEvt;
    logic [15:0] thValue;

    ////////////////////////////////////////////////////////////////////////
    // Converter bank
    spss_converter u_conv (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .photoPulse(photoPulse),
        .cif(cif)
    );

    // Settings pass straight to the converters
    assign cif.tick = r_reg.tick;
    assign cif.start = r_reg.start;
    assign cif.abort = r_reg.abort;
    assign cif.gain = analogGainSetting;
    assign cif.stepCount = integStepCount;
    assign cif.stepSize = integStepSize;

    // GPIO as start/stop gate when synchronisation is on
    assign measureRun = measureEnableBit && (!gpioSyncEnable || gpioIn);

    // Threshold channel picked from the converter outputs
    assign thValue = (thresholdChannel < 3'h6) ? cif.result[thresholdChannel] : '0;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        r_next = r_reg;
        r_next.start = 1'b0;
        r_next.abort = 1'b0;
        r_next.tick = 1'b0;
        r_next.valid = 1'b0;
        irqEvt = 1'b0;
        if (r_reg.st == spss_pkg::ST_INIT) begin
            // No transfer is accepted until the count runs out
            if (r_reg.initCnt == 14'(INIT_CYCLES - 1)) begin
                r_next.st = spss_pkg::ST_SLEEP;
            end else begin
                r_next.initCnt = r_reg.initCnt + 14'h1;
            end
        end else begin
            // Base tick divider only runs with the oscillator
            if (r_reg.osc) begin
                if (r_reg.tickCnt == 8'(spss_pkg::TICK_CYCLES - 1)) begin
                    r_next.tickCnt = '0;
                    r_next.tick = 1'b1;
                end else begin
                    r_next.tickCnt = r_reg.tickCnt + 8'h1;
                end
            end
            // Store each pass; threshold check after the last one
            if (r_reg.st == spss_pkg::ST_MEASURE && cif.done) begin
                for (int i = 0; i < spss_pkg::NUM_CONV; i++) begin
                    r_next.mem[(r_reg.pass ? spss_pkg::NUM_CONV : 0) + i] = cif.result[i];
                end
                if (r_reg.pass) begin
                    r_next.valid = 1'b1;
                    irqEvt = (thValue < thresholdLow) || (thValue > thresholdHigh);
                end
            end
            // Set wins over a clear in the same cycle
            if (irqEvt) begin
                r_next.irqPend = 1'b1;
            end else if (irqClear) begin
                r_next.irqPend = 1'b0;
            end
            if (irqEvt && sleepAfterIrqBit) begin
                r_next.irqSleep = 1'b1;
            end else if (irqSleepClear) begin
                r_next.irqSleep = 1'b0;
            end
            // Power state: sleep overrides, settings are never altered
            if (r_next.irqSleep || !powerOnBit) begin
                r_next.st = spss_pkg::ST_SLEEP;
            end else if (!measureRun) begin
                r_next.st = spss_pkg::ST_IDLE;
            end else begin
                case (r_reg.st)
                    spss_pkg::ST_MEASURE: begin
                        if (cif.done) begin
                            if (!r_reg.pass) begin
                                r_next.pass = 1'b1;
                                r_next.start = 1'b1;
                            end else if (waitEnableBit) begin
                                r_next.st = spss_pkg::ST_WAIT;
                                r_next.waitCnt = '0;
                                r_next.waitSteps = '0;
                            end else begin
                                r_next.pass = 1'b0;
                                r_next.start = 1'b1;
                            end
                        end
                    end
                    spss_pkg::ST_WAIT: begin
                        if (r_reg.tick) begin
                            if (r_reg.waitCnt == 10'(spss_pkg::WAIT_TICKS - 1)) begin
                                r_next.waitCnt = '0;
                                if (r_reg.waitSteps == waitTime) begin
                                    r_next.st = spss_pkg::ST_MEASURE;
                                    r_next.pass = 1'b0;
                                    r_next.start = 1'b1;
                                end else begin
                                    r_next.waitSteps = r_reg.waitSteps + 8'h1;
                                end
                            end else begin
                                r_next.waitCnt = r_reg.waitCnt + 10'h1;
                            end
                        end
                    end
                    default: begin
                        r_next.st = spss_pkg::ST_MEASURE;
                        r_next.pass = 1'b0;
                        r_next.start = 1'b1;
                    end
                endcase
            end
            // A measurement cut short stops the converters
            if (r_reg.st == spss_pkg::ST_MEASURE && r_next.st != spss_pkg::ST_MEASURE) begin
                r_next.abort = 1'b1;
            end
        end
        // Output flops follow the next state
        r_next.nack = (r_next.st == spss_pkg::ST_INIT);
        r_next.osc = (r_next.st != spss_pkg::ST_INIT) && (r_next.st != spss_pkg::ST_SLEEP);
        r_next.meas = (r_next.st == spss_pkg::ST_MEASURE);
        r_next.wake = (r_next.st == spss_pkg::ST_SLEEP) && i2cActive;
        r_next.gpioOeN = gpioSyncEnable;
        r_next.gpioOut = (r_next.st == spss_pkg::ST_MEASURE);
        r_next.led = ledEnable && (!ledSyncEnable || gpioIn);
        r_next.readData = (resultAddr < 4'hc) ? r_reg.mem[resultAddr] : '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register; reset starts initialisation with GPIO as output
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r_reg <= '0;
            r_reg.nack <= spss_pkg::NACK_RST;
            r_reg.gpioOeN <= spss_pkg::GPIO_OEN_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from the state flops, except intOut tied low
    assign resultData = r_reg.readData;
    assign powerState = r_reg.st;
    assign oscEnable = r_reg.osc;
    assign measureCircuitOn = r_reg.meas;
    assign i2cNack = r_reg.nack;
    assign i2cWake = r_reg.wake;
    assign irqSleepFlag = r_reg.irqSleep;
    assign dataValid = r_reg.valid;
    assign intOut = 1'b0; // Open drain: only ever pulls low
    assign intOeN = !r_reg.irqPend;
    assign gpioOut = r_reg.gpioOut;
    assign gpioOeN = r_reg.gpioOeN;
    assign ledDriverPin = r_reg.led;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_inSleep;
        powerState == spss_pkg::ST_SLEEP;
    endsequence
    sequence s_irqSleepEntry;
        irqSleepFlag && powerState == spss_pkg::ST_SLEEP;
    endsequence

    property p_initNack;
        @(posedge sys_clk) disable iff (sys_rst)
        powerState == spss_pkg::ST_INIT |-> i2cNack && !oscEnable;
    endproperty
    a_initNack: assert property (p_initNack) else $error("init without nack");

    property p_initExit;
        @(posedge sys_clk) disable iff (sys_rst)
        ($past(powerState) == spss_pkg::ST_INIT && powerState != spss_pkg::ST_INIT)
        |-> s_inSleep;
    endproperty
    a_initExit: assert property (p_initExit) else $error("init not left to sleep");

    property p_sleepOsc;
        @(posedge sys_clk) disable iff (sys_rst)
        s_inSleep |-> !oscEnable && !measureCircuitOn;
    endproperty
    a_sleepOsc: assert property (p_sleepOsc) else $error("oscillator on in sleep");

    property p_wake;
        @(posedge sys_clk) disable iff (sys_rst)
        (s_inSleep and (i2cActive && !powerOnBit)) |=> s_inSleep and i2cWake;
    endproperty
    a_wake: assert property (p_wake) else $error("serial wake missing");

    property p_ponIdle;
        @(posedge sys_clk) disable iff (sys_rst)
        (s_inSleep and (powerOnBit && !measureEnableBit && !irqSleepFlag && !irqSleepClear))
        |=> powerState == spss_pkg::ST_IDLE && oscEnable;
    endproperty
    a_ponIdle: assert property (p_ponIdle) else $error("no idle on power-on");

    property p_active;
        @(posedge sys_clk) disable iff (sys_rst)
        (powerState == spss_pkg::ST_IDLE && powerOnBit && measureRun && !irqSleepFlag
            && !irqSleepClear) |=> powerState == spss_pkg::ST_MEASURE ##1 cif.busy;
    endproperty
    a_active: assert property (p_active) else $error("measurement not started");

    property p_stop;
        @(posedge sys_clk) disable iff (sys_rst)
        ((powerState == spss_pkg::ST_MEASURE || powerState == spss_pkg::ST_WAIT)
            && !measureEnableBit && powerOnBit && !irqSleepFlag && !cif.done)
        |=> powerState == spss_pkg::ST_IDLE;
    endproperty
    a_stop: assert property (p_stop) else $error("measurement not stopped");

    property p_irqSleep;
        @(posedge sys_clk) disable iff (sys_rst)
        (irqEvt && sleepAfterIrqBit) |=> s_irqSleepEntry ##1 (irqSleepFlag || $past(irqSleepClear));
    endproperty
    a_irqSleep: assert property (p_irqSleep) else $error("no sleep after irq");

    property p_irqHold;
        @(posedge sys_clk) disable iff (sys_rst)
        (irqSleepFlag && !irqSleepClear) |=> s_irqSleepEntry;
    endproperty
    a_irqHold: assert property (p_irqHold) else $error("irq sleep left early");

    property p_intPin;
        @(posedge sys_clk) disable iff (sys_rst)
        // A clear right after the event may release the pin on the second cycle
        irqEvt |=> !intOeN ##1 (!intOeN || $past(irqClear));
    endproperty
    a_intPin: assert property (p_intPin) else $error("interrupt pin not low");

    property p_waitIdle;
        @(posedge sys_clk) disable iff (sys_rst)
        powerState == spss_pkg::ST_WAIT |-> !measureCircuitOn && !cif.busy;
    endproperty
    a_waitIdle: assert property (p_waitIdle) else $error("circuit on in wait");

    property p_gpioRst;
        @(posedge sys_clk)
        $past(sys_rst) |-> !gpioOeN;
    endproperty
    a_gpioRst: assert property (p_gpioRst) else $error("gpio not output at reset");

    property p_ledSync;
        @(posedge sys_clk) disable iff (sys_rst)
        (ledSyncEnable && !gpioIn) |=> !ledDriverPin;
    endproperty
    a_ledSync: assert property (p_ledSync) else $error("led not gated by gpio");
endmodule // spss_sequencer
`default_nettype wire

// *** spss_sequencer_note_unused.sv ***
// Spare source file of the sequencer; it holds no logic

// *** spss_host_model.sv ***
// Host-side model that drives the control bits and serial bus activity
`timescale 1ns/1ps
`default_nettype none
module spss_host_model (
    // Clock and observed state
    input wire logic sys_clk,
    input wire logic [2:0] powerState,
    // Control bits toward the sequencer
    output logic powerOnBit,
    output logic measureEnableBit,
    output logic sleepAfterIrqBit,
    output logic irqSleepClear,
    output logic i2cActive
);
    ////////////////////////////////////////////////////////////////////////////////
    // Quiet bus and cleared bits from time zero
    initial begin
        {powerOnBit, measureEnableBit, sleepAfterIrqBit, irqSleepClear, i2cActive} = 5'h00;
    end
    // Nothing is sent until the device has left initialisation
    task automatic hold_off(output logic ok);
        ok = 1'h0;
        for (int i = 0; i < 200 && !ok; i++) begin
            @(posedge sys_clk);
            #1;
            ok = (powerState !== spss_pkg::ST_INIT);
        end
    endtask
    // One register write; the bus is busy for a cycle before the bits land
    task automatic write_ctrl(input logic power_on_bit, input logic men, input logic sleep_after_irq_bit);
        i2cActive = 1'h1;
        @(posedge sys_clk);
        #1;
        {powerOnBit, measureEnableBit, sleepAfterIrqBit} = {power_on_bit, men, sleep_after_irq_bit};
        i2cActive = 1'h0;
    endtask
    // Clear of the interrupt sleep flag, one cycle wide
    task automatic clear_sleep;
        irqSleepClear = 1'h1;
        @(posedge sys_clk);
        #1;
        irqSleepClear = 1'h0;
    endtask
endmodule // spss_host_model
`default_nettype wire

// *** testbench.sv ***
// Self-checking testbench of the power and measurement sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic sys_clk, sys_rst, waitEnableBit, irqClear, gpioSyncEnable, ledSyncEnable;
    logic ledEnable, gpioIn, i2cActive, powerOnBit, measureEnableBit, sleepAfterIrqBit;
    logic irqSleepClear, oscEnable, measureCircuitOn, i2cNack, i2cWake, irqSleepFlag;
    logic dataValid, intOeN, intOut, gpioOut, gpioOeN, ledDriverPin, ok;
    logic [7:0] integStepCount, waitTime;
    logic [15:0] integStepSize, thresholdLow, thresholdHigh, resultData;
    logic [3:0] analogGainSetting, resultAddr;
    logic [2:0] thresholdChannel, powerState;
    logic [5:0] photoPulse;
    int num_errors = 0;
    int num_checks = 0;
    int n;
    ////////////////////////////////////////////////////////////////////////////////
    // Short init count keeps the run brief
    spss_sequencer #(.INIT_CYCLES(20)) i_dut (.sys_clk, .sys_rst, .powerOnBit,
        .measureEnableBit, .waitEnableBit, .sleepAfterIrqBit, .irqSleepClear, .irqClear,
        .gpioSyncEnable, .ledSyncEnable, .ledEnable, .integStepCount, .integStepSize,
        .waitTime, .analogGainSetting, .thresholdLow, .thresholdHigh, .thresholdChannel,
        .i2cActive, .photoPulse, .resultAddr, .resultData, .powerState, .oscEnable,
        .measureCircuitOn, .i2cNack, .i2cWake, .irqSleepFlag, .dataValid, .intOut,
        .intOeN, .gpioIn, .gpioOut, .gpioOeN, .ledDriverPin);
    spss_host_model i_host (.sys_clk, .powerState, .powerOnBit, .measureEnableBit,
        .sleepAfterIrqBit, .irqSleepClear, .i2cActive);
    // 50 MHz clock
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence and from any timeout
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Inputs move 1 ns after the edge, outputs read there too
    task automatic step;
        @(posedge sys_clk);
        #1;
    endtask
    // Cycles until the next result pulse; a missing pulse ends the run
    task automatic wait_dv(output int cnt);
        cnt = 0;
        do begin
            step();
            cnt++;
        end while (dataValid !== 1'h1 && cnt < 3000);
        if (cnt >= 3000) begin
            num_errors++;
            complete_run();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        sys_rst = 1'h1;
        {waitEnableBit, irqClear, gpioSyncEnable, ledSyncEnable, ledEnable} = 5'h00;
        {integStepCount, integStepSize, waitTime} = {8'h01, 16'h0001, 8'h00};
        {analogGainSetting, thresholdLow, thresholdHigh} = {4'h0, 16'h0000, 16'hffff};
        {thresholdChannel, photoPulse, resultAddr, gpioIn} = {3'h0, 6'h3f, 4'h0, 1'h1};
        repeat (10) step();
        sys_rst = 1'h0;
        step();
        chk("state", powerState, spss_pkg::ST_INIT);
        chk("nack", i2cNack, 1'h1);
        chk("gpio_oen", gpioOeN, 1'h0);
        chk("int_oen", intOeN, 1'h1);
        i_host.hold_off(ok);
        chk("init_done", ok, 1'h1);
        // A device stuck in initialisation ends the run at once
        if (ok !== 1'h1) complete_run();
        chk("state", powerState, spss_pkg::ST_SLEEP);
        chk("osc", oscEnable, 1'h0);
        chk("nack", i2cNack, 1'h0);
        i_host.write_ctrl(1'h0, 1'h0, 1'h0);
        chk("wake", i2cWake, 1'h1);
        chk("state", powerState, spss_pkg::ST_SLEEP);
        step();
        chk("wake", i2cWake, 1'h0);
        chk("state", powerState, spss_pkg::ST_SLEEP);
        i_host.write_ctrl(1'h1, 1'h0, 1'h0);
        step();
        chk("state", powerState, spss_pkg::ST_IDLE);
        chk("osc", oscEnable, 1'h1);
        i_host.write_ctrl(1'h1, 1'h1, 1'h0);
        step();
        chk("state", powerState, spss_pkg::ST_MEASURE);
        chk("circuit", measureCircuitOn, 1'h1);
        chk("gpio_out", gpioOut, 1'h1);
        // Two passes of four ticks each, 139 cycles a tick
        wait_dv(n);
        wait_dv(n);
        chk("period", 16'(n >= 1112 && n <= 1251), 16'h0001);
        chk("result", 16'(resultData >= 16'h0200), 16'h0001);
        resultAddr = 4'hc;
        step();
        step();
        chk("result_oob", resultData, 16'h0000);
        waitEnableBit = 1'h1;
        wait_dv(n);
        for (int i = 0; i < 3 && powerState !== spss_pkg::ST_WAIT; i++) step();
        chk("state", powerState, spss_pkg::ST_WAIT);
        chk("circuit", measureCircuitOn, 1'h0);
        i_host.write_ctrl(1'h1, 1'h0, 1'h0);
        step();
        chk("state", powerState, spss_pkg::ST_IDLE);
        // Sync input gates measurement and LED
        {waitEnableBit, gpioSyncEnable, ledSyncEnable, ledEnable, gpioIn} = 5'h0e;
        i_host.write_ctrl(1'h1, 1'h1, 1'h0);
        step();
        chk("gpio_oen", gpioOeN, 1'h1);
        chk("led", ledDriverPin, 1'h0);
        chk("gated", 16'(powerState === spss_pkg::ST_MEASURE), 16'h0000);
        gpioIn = 1'h1;
        step();
        step();
        chk("state", powerState, spss_pkg::ST_MEASURE);
        chk("led", ledDriverPin, 1'h1);
        gpioIn = 1'h0;
        step();
        step();
        chk("gated", 16'(powerState === spss_pkg::ST_MEASURE), 16'h0000);
        chk("led", ledDriverPin, 1'h0);
        {gpioSyncEnable, ledSyncEnable, gpioIn, thresholdHigh} = {3'h1, 16'h000a};
        // Threshold event with sleep after interrupt
        i_host.write_ctrl(1'h1, 1'h1, 1'h1);
        wait_dv(n);
        for (int i = 0; i < 3 && intOeN !== 1'h0; i++) step();
        step();
        chk("int_oen", intOeN, 1'h0);
        chk("int_out", intOut, 1'h0);
        chk("sleep_flag", irqSleepFlag, 1'h1);
        chk("state", powerState, spss_pkg::ST_SLEEP);
        chk("osc", oscEnable, 1'h0);
        repeat (5) step();
        chk("state", powerState, spss_pkg::ST_SLEEP);
        thresholdHigh = 16'hffff;
        irqClear = 1'h1;
        i_host.clear_sleep();
        irqClear = 1'h0;
        step();
        chk("sleep_flag", irqSleepFlag, 1'h0);
        chk("state", powerState, spss_pkg::ST_MEASURE);
        chk("int_oen", intOeN, 1'h1);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
